// [dct_pkg.sv]
// Constants, register map and carrier types of the debug comparator trigger block.
// Assumes one system clock; the core bus sample arrives on that same clock.
package dct_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int AW = 23;
  localparam int DW = 16;
  localparam int NCH = 4;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_MAIN     = 8'h00;
  localparam logic [7:0] OFS_RANGE    = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_NEXT     = 8'h0C;
  localparam logic [3:0] CMP_BANK_LO  = 4'h1;
  localparam logic [3:0] CMP_BANK_HI  = 4'h4;
  localparam logic [3:0] OFS_CMP_CTL  = 4'h0;
  localparam logic [3:0] OFS_CMP_ADDR = 4'h4;
  localparam logic [3:0] OFS_CMP_DATA = 4'h8;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MC_ARM = 0;
  localparam int MC_FORCE = 1;
  localparam int MC_ALIGN = 2;
  localparam int MC_BRK_EN = 4;
  localparam int MC_TRACE_EN = 5;
  localparam int RC_AB = 0;
  localparam int RC_CD = 1;
  localparam int RC_OUTSIDE = 2;
  localparam int CC_EN = 0;
  localparam int CC_TAG = 1;
  localparam int CC_BRK = 2;
  localparam int CC_RW = 3;
  localparam int CC_RWE = 4;
  localparam int CC_SZE = 5;
  localparam int CC_SZ = 6;
  localparam int CC_NDB = 7;
  localparam int FL_MATCH = 4;
  localparam int CD_MASK = 16;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [5:0] MAIN_RST = 6'h00;
  localparam logic [2:0] RANGE_RST = 3'h0;
  localparam logic [7:0] NEXT_RST = 8'hFF;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {ALIGN_BEGIN, ALIGN_MID, ALIGN_END} dct_align_e;
  typedef enum logic [2:0] {ST_IDLE, ST_ONE, ST_TWO, ST_THREE, ST_FINAL} dct_state_e;

  typedef struct packed {
    logic          en;
    logic          tag;
    logic          break_on_match;
    logic          rw;
    logic          direction_compare_enable;
    logic          access_size_compare_enable;
    logic          sz;
    logic          match_on_difference;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [DW-1:0] mask;
  } dct_cmp_s;

  // rd: 1 = read; byte_acc: 1 = byte access; fetch: opcode fetch
  typedef struct packed {
    logic          valid;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic          rd;
    logic          byte_acc;
    logic          fetch;
    logic          vector;
  } dct_bus_s;

endpackage : dct_pkg

// [dct_trigger.sv]
// Debug comparators, range windows, trigger priority and session sequencer.
// Assumes a classic Wishbone master and a core bus sample on clk_i.
//
// What this block does
// [R1] Equivalence: all masked-in data bits must equal
// [R2] Equivalence, empty mask: address alone decides
// [R3] Difference: any masked-in differing bit matches
// [R4] Difference, empty mask: never matches
// [R5] Difference option only on comparators A, C
// [R6] A-B range uses A data, mask, direction
// [R7] C-D range uses C settings, direction untagged
// [R8] Size compare ignored in range modes
// [R9] A and C tag settings govern ranges
// [R10] Range needs both pair enables set
// [R11] A and C break settings govern ranges
// [R12] Tagged ranges resolved to word granularity
// [R13] Inside range needs both limits matching
// [R14] Inside: straddling word judged by aligned address
// [R15] Outside: either limit alone; aligned address judged
// [R16] Software sets extreme limit for forced outside
// [R17] Vector fetches never produce tag hits
// [R18] Forced match steps sequencer, sets flags
// [R19] Forced trigger fires on address appearance
// [R20] Tag opcodes; core tag hit steps sequencer
// [R21] Software force: final state or disarm
// [R22] Software force breakpoint: now or after trace
// [R23] Lowest match channel wins simultaneous matches
//
// The Wishbone slave port and the address map were chosen for this implementation.
module dct_trigger
  import dct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire dct_bus_s    bus_i,
  input  wire logic [3:0]  taghit_i,
  input  wire logic        trace_done_i,
  output logic      [3:0]  tag_o,
  output logic             brk_req_o,
  output logic             trace_software_force_event_o,
  output logic             armed_o,
  output logic      [2:0]  state_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic data_ok(input dct_cmp_s c, input logic [DW-1:0] d);
    logic [DW-1:0] m;
    m = (d ^ c.data) & c.mask;
    return c.match_on_difference ? (|m) : ~(|m); // see [R1] see [R2] see [R3] see [R4]
  endfunction : data_ok

  function automatic logic dir_ok(input dct_cmp_s c, input logic rd);
    return c.tag | ~c.direction_compare_enable | (c.rw == rd);
  endfunction : dir_ok

  function automatic dct_state_e to_state(input logic [1:0] code);
    case (code)
      2'h0: to_state = ST_ONE;
      2'h1: to_state = ST_TWO;
      2'h2: to_state = ST_THREE;
      default: to_state = ST_FINAL;
    endcase
  endfunction : to_state

  // ************************************************************
  // Register file
  // ************************************************************
  logic [5:0]  main_ctl;
  logic [2:0]  range_ctl;
  logic [7:0]  next_sel;
  logic [3:0]  match_flags;
  dct_cmp_s    cmp [NCH];
  dct_state_e  st;
  dct_state_e  next_st;
  logic        req;
  logic        wr;
  logic        sw_force;
  logic        arm_wr;
  logic [1:0]  ci;
  logic        cmp_sel;
  logic [31:0] ctl_rd;
  dct_align_e  align;
  logic        trace_en;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i;
  assign ci       = 2'(wb_adr_i[5:4] - 2'h1);
  assign cmp_sel  = (wb_adr_i[7:4] >= CMP_BANK_LO) && (wb_adr_i[7:4] <= CMP_BANK_HI);
  assign sw_force = wr && wb_adr_i == OFS_MAIN && wb_sel_i[0] && wb_dat_i[MC_FORCE];
  assign arm_wr   = wr && wb_adr_i == OFS_MAIN && wb_sel_i[0];
  assign align    = dct_align_e'(main_ctl[MC_ALIGN +: 2]);
  assign trace_en = main_ctl[MC_TRACE_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Force bit is a strobe and never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_ctl  <= MAIN_RST;
      range_ctl <= RANGE_RST;
      next_sel  <= NEXT_RST;
    end else if (wr) begin
      if (wb_adr_i == OFS_MAIN && wb_sel_i[0]) begin
        main_ctl <= wb_dat_i[5:0] & ~6'h03;
      end
      if (wb_adr_i == OFS_RANGE && wb_sel_i[0]) begin
        range_ctl <= wb_dat_i[2:0];
      end
      if (wb_adr_i == OFS_NEXT && wb_sel_i[0]) begin
        next_sel <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NCH; k++) begin
        cmp[k] <= '0;
      end
    end else if (wr && cmp_sel) begin
      case (wb_adr_i[3:0])
        OFS_CMP_CTL: begin
          if (wb_sel_i[0]) begin
            cmp[ci].en  <= wb_dat_i[CC_EN];
            cmp[ci].tag <= wb_dat_i[CC_TAG];
            cmp[ci].break_on_match <= wb_dat_i[CC_BRK];
            cmp[ci].rw  <= wb_dat_i[CC_RW];
            cmp[ci].direction_compare_enable <= wb_dat_i[CC_RWE];
            cmp[ci].access_size_compare_enable <= ci[0] & wb_dat_i[CC_SZE];
            cmp[ci].sz  <= ci[0] & wb_dat_i[CC_SZ];
            cmp[ci].match_on_difference <= ~ci[0] & wb_dat_i[CC_NDB]; // see [R5]
          end
        end
        OFS_CMP_ADDR: begin
          cmp[ci].addr <= AW'(be_merge(32'(cmp[ci].addr), wb_dat_i, wb_sel_i));
        end
        OFS_CMP_DATA: begin
          {cmp[ci].mask, cmp[ci].data} <= be_merge({cmp[ci].mask, cmp[ci].data}, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    ctl_rd = 32'h0;
    ctl_rd[CC_EN]  = cmp[ci].en;
    ctl_rd[CC_TAG] = cmp[ci].tag;
    ctl_rd[CC_BRK] = cmp[ci].break_on_match;
    ctl_rd[CC_RW]  = cmp[ci].rw;
    ctl_rd[CC_RWE] = cmp[ci].direction_compare_enable;
    ctl_rd[CC_SZE] = cmp[ci].access_size_compare_enable;
    ctl_rd[CC_SZ]  = cmp[ci].sz;
    ctl_rd[CC_NDB] = cmp[ci].match_on_difference;
  end

  // Unmapped addresses are acknowledged and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= 32'h0;
      if (wb_adr_i == OFS_MAIN) begin
        wb_dat_o <= {26'h0, main_ctl[5:2], 1'b0, armed_o};
      end else if (wb_adr_i == OFS_RANGE) begin
        wb_dat_o <= {29'h0, range_ctl};
      end else if (wb_adr_i == OFS_FLAGS) begin
        wb_dat_o <= {24'h0, match_flags, 1'b0, state_o};
      end else if (wb_adr_i == OFS_NEXT) begin
        wb_dat_o <= {24'h0, next_sel};
      end else if (cmp_sel) begin
        case (wb_adr_i[3:0])
          OFS_CMP_CTL:  wb_dat_o <= ctl_rd;
          OFS_CMP_ADDR: wb_dat_o <= 32'(cmp[ci].addr);
          OFS_CMP_DATA: wb_dat_o <= {cmp[ci].mask, cmp[ci].data};
          default:      wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ************************************************************
  // Comparators and ranges
  // ************************************************************
  logic [NCH-1:0] exact;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] ch_tag;
  logic [NCH-1:0] ch_brk;
  logic [1:0]     range_on;
  logic [1:0]     range_hit;

  always_comb begin
    logic lo_ok;
    logic hi_ok;
    dct_cmp_s q;
    lo_ok = 1'b0;
    hi_ok = 1'b0;
    q = '0;
    for (int k = 0; k < NCH; k++) begin
      exact[k] = bus_i.valid && cmp[k].en && bus_i.addr == cmp[k].addr && dir_ok(cmp[k], bus_i.rd);
      if (k % 2 == 0) begin
        exact[k] = exact[k] & data_ok(cmp[k], bus_i.data);
      end else begin
        exact[k] = exact[k] & (cmp[k].tag | ~cmp[k].access_size_compare_enable | (cmp[k].sz == bus_i.byte_acc));
      end
    end
    for (int p = 0; p < 2; p++) begin
      q = cmp[2*p];
      range_on[p] = range_ctl[p] & cmp[2*p].en & cmp[2*p+1].en; // see [R10]
      if (q.tag) begin
        lo_ok = bus_i.addr[AW-1:1] >= cmp[2*p].addr[AW-1:1]; // see [R12]
        hi_ok = bus_i.addr[AW-1:1] <= cmp[2*p+1].addr[AW-1:1];
      end else begin
        lo_ok = bus_i.addr >= cmp[2*p].addr; // see [R14]
        hi_ok = bus_i.addr <= cmp[2*p+1].addr;
      end
      range_hit[p] = bus_i.valid && range_on[p]
                     && (range_ctl[RC_OUTSIDE] ? (!lo_ok || !hi_ok) : (lo_ok && hi_ok)) // see [R13] see [R15]
                     && dir_ok(q, bus_i.rd) && data_ok(q, bus_i.data); // see [R6] see [R7] see [R8]
      hit[2*p]      = range_on[p] ? range_hit[p] : exact[2*p];
      hit[2*p+1]    = range_on[p] ? 1'b0 : exact[2*p+1];
      ch_tag[2*p]   = cmp[2*p].tag; // see [R9]
      ch_tag[2*p+1] = cmp[2*p+1].tag;
      ch_brk[2*p]   = cmp[2*p].break_on_match; // see [R11]
      ch_brk[2*p+1] = cmp[2*p+1].break_on_match;
    end
  end

  // ************************************************************
  // Trigger sources and priority
  // ************************************************************
  logic [NCH-1:0] ev;
  logic [NCH-1:0] win;
  logic [1:0]     win_ch;

  // Untagged matches trigger in the same cycle as the address
  assign ev  = armed_o ? ((hit & ~ch_tag) | taghit_i) : 4'h0; // see [R18] see [R19] see [R20]
  assign win = ev & (~ev + 4'h1); // see [R23]

  always_comb begin
    win_ch = 2'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (ev[k]) begin
        win_ch = 2'(k);
      end
    end
  end

  // Tags go to the core with the opcode fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag_o <= 4'h0;
    end else begin
      tag_o <= (armed_o && bus_i.fetch && !bus_i.vector) ? (hit & ch_tag) : 4'h0; // see [R17] see [R20]
    end
  end

  // ************************************************************
  // Session sequencer
  // ************************************************************
  logic brk_pend;
  logic sw_end;
  logic final_exit;

  // End alignment or no tracing: force ends the session at once
  assign sw_end     = align == ALIGN_END || !trace_en;
  assign final_exit = st == ST_FINAL && (sw_end || trace_done_i || brk_pend);

  always_comb begin
    next_st = st;
    if (sw_force) begin
      next_st = sw_end ? ST_IDLE : ST_FINAL; // see [R21]
    end else if (st == ST_FINAL) begin
      if (final_exit) begin
        next_st = ST_IDLE;
      end
    end else if (st != ST_IDLE && |ev) begin
      next_st = ch_brk[win_ch] ? ST_FINAL : to_state(next_sel[2*win_ch +: 2]); // see [R18]
    end else if (arm_wr) begin
      next_st = wb_dat_i[MC_ARM] ? (st == ST_IDLE ? ST_ONE : st) : ST_IDLE;
    end
  end

  // Hardware disarm outranks a concurrent arm write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign armed_o = st != ST_IDLE;
  assign state_o = 3'(st);

  // The clear made by arming wins; hits in that cycle are gated off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_flags <= 4'h0;
    end else if (arm_wr && wb_dat_i[MC_ARM] && !armed_o) begin
      match_flags <= win;
    end else begin
      match_flags <= match_flags | win; // see [R18]
    end
  end

  // Channel break passes through final for one cycle only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_pend <= 1'b0;
    end else if (!sw_force && st != ST_FINAL && st != ST_IDLE && |ev) begin
      brk_pend <= ch_brk[win_ch];
    end else if (st == ST_FINAL) begin
      brk_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_req_o    <= 1'b0;
      trace_software_force_event_o <= 1'b0;
    end else begin
      brk_req_o <= (sw_force && sw_end && main_ctl[MC_BRK_EN]) // see [R22]
                   || (!sw_force && final_exit && main_ctl[MC_BRK_EN] && !brk_pend) // see [R22]
                   || (!sw_force && st != ST_FINAL && st != ST_IDLE && |ev && ch_brk[win_ch]);
      trace_software_force_event_o <= next_st == ST_FINAL && st != ST_FINAL && trace_en;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_force_end;
    sw_force && sw_end;
  endsequence
  sequence s_force_trace;
    sw_force && !sw_end;
  endsequence

  chk_eq_addr_only: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2]
    (!range_on[0] && bus_i.valid && cmp[0].en && !cmp[0].match_on_difference && cmp[0].mask == 16'h0
     && !cmp[0].direction_compare_enable && bus_i.addr == cmp[0].addr) |-> hit[0])
    else $error("equivalence with empty mask missed an address match");
  chk_ndb_empty: assert property (@(posedge clk_i) disable iff (rst_i) // see [R4]
    (!range_on[0] && cmp[0].match_on_difference && cmp[0].mask == 16'h0) |-> !hit[0])
    else $error("difference with empty mask matched");
  chk_ndb_differs: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
    (!range_on[0] && bus_i.valid && cmp[0].en && cmp[0].match_on_difference && !cmp[0].direction_compare_enable
     && bus_i.addr == cmp[0].addr && ((bus_i.data ^ cmp[0].data) & cmp[0].mask) != 16'h0) |-> hit[0])
    else $error("difference match missed");
  chk_bd_no_ndb: assert property (@(posedge clk_i) disable iff (rst_i) // see [R5]
    !cmp[1].match_on_difference && !cmp[3].match_on_difference)
    else $error("difference option present on B or D");
  chk_range_enables: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
    (range_ctl[RC_AB] && !(cmp[0].en && cmp[1].en)) |-> hit[0] == exact[0] && hit[1] == exact[1])
    else $error("range active without both enables");
  chk_vector_tags: assert property (@(posedge clk_i) disable iff (rst_i) // see [R17]
    bus_i.vector |=> tag_o == 4'h0)
    else $error("tag raised on vector fetch");
  chk_low_channel: assert property (@(posedge clk_i) disable iff (rst_i) // see [R23]
    (ev[0] && ev[2] && !sw_force && st != ST_FINAL && !arm_wr) |=> match_flags[0] && !$rose(match_flags[2]))
    else $error("lower channel lost priority");
  chk_force_end: assert property (@(posedge clk_i) disable iff (rst_i) // see [R21]
    s_force_end |=> st == ST_IDLE && (brk_req_o == $past(main_ctl[MC_BRK_EN])))
    else $error("end-aligned force did not disarm");
  chk_force_trace: assert property (@(posedge clk_i) disable iff (rst_i) // see [R21]
    s_force_trace |=> st == ST_FINAL ##0 trace_software_force_event_o)
    else $error("force did not reach final state");
  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not single cycle");
endmodule : dct_trigger

// [dct_core_model.sv]
// Core-side model: turns tags from the debug logic into tag hits at execution.
// Assumes one outstanding tag at a time; the delay input sets the pipeline depth.
module dct_core_model
  import dct_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] tag_i,
  input  wire logic [3:0] exec_delay_i,
  output logic      [3:0] taghit_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] held;
  logic [3:0] cnt;

  // ************************************************************
  // Instruction queue delay
  // ************************************************************
  // Delay of zero is not modelled; a tag always waits at least one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held     <= 4'h0;
      cnt      <= 4'h0;
      taghit_o <= 4'h0;
    end else begin
      taghit_o <= 4'h0;
      if (tag_i != 4'h0 && cnt == 4'h0) begin
        held <= tag_i;
        cnt  <= exec_delay_i;
      end else if (cnt == 4'h1) begin
        taghit_o <= held;
        cnt      <= 4'h0;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : dct_core_model

// [dct_trigger_tb_top.sv]
// Self-checking bench for the debug comparator trigger block.
// Assumes dct_pkg and dct_core_model; all inputs change right after rising edges.
module dct_trigger_tb_top
  import dct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, trace_done;
  logic        brk_req, trace_software_force_event, armed;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_rdat, wb_q, r;
  logic [3:0]  taghit, tag, dly;
  logic [2:0]  state;
  dct_bus_s    bus;
  int          fails, n_checks, cycles, brk_cnt, software_force_event_cnt, seed, b0, t0;

  dct_trigger dct_trigger_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hF), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .bus_i(bus), .taghit_i(taghit), .trace_done_i(trace_done), .tag_o(tag),
    .brk_req_o(brk_req), .trace_software_force_event_o(trace_software_force_event), .armed_o(armed), .state_o(state));
  dct_core_model dct_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .tag_i(tag),
    .exec_delay_i(dly), .taghit_o(taghit));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    rnd = $random(seed);
  endfunction : rnd

  // Released bus shows changing junk so stale values cannot match
  function automatic dct_bus_s junk();
    logic [63:0] j;
    j = {rnd(), rnd()};
    junk = j[43:0];
    junk.valid = 1'b0;
  endfunction : junk

  function automatic dct_bus_s mk(input logic [22:0] a, input logic [15:0] d, input logic f, v);
    mk = '0;
    mk.valid = 1'b1;
    mk.addr = a;
    mk.data = d;
    mk.fetch = f;
    mk.vector = v;
  endfunction : mk

  function automatic logic em(input logic n, input logic [15:0] d, m, b);
    em = n ? |((b ^ d) & m) : (((b ^ d) & m) == 16'h0000);
  endfunction : em

  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    wb_q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : wb

  task automatic cmp(input int k, input logic [7:0] ctl, input logic [22:0] a, input logic [15:0] d, m);
    wb(1'b1, {4'(k + 1), OFS_CMP_CTL}, {24'h0, ctl});
    wb(1'b1, {4'(k + 1), OFS_CMP_ADDR}, {9'h0, a});
    wb(1'b1, {4'(k + 1), OFS_CMP_DATA}, {m, d});
  endtask : cmp

  // Arm, one bus cycle, optional wait, then state and flags
  task automatic fire(input logic [22:0] a, input logic f, v, input int w, input logic [2:0] es,
                      input logic [3:0] ef, input logic [15:0] d = 16'h0000);
    wb(1'b1, OFS_MAIN, 32'h1);
    @(posedge clk_i);
    bus <= mk(a, d, f, v);
    @(posedge clk_i);
    bus <= junk();
    repeat (w) @(posedge clk_i);
    #1;
    chk(state, es);
    wb(1'b0, OFS_FLAGS, 32'h0);
    chk({wb_q[7:4], wb_q[2:0]}, {ef, es});
    wb(1'b1, OFS_MAIN, 32'h0);
  endtask : fire

  // ************************************************************
  // Clock, timeout and event counters
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (brk_req === 1'b1) brk_cnt++;
    if (trace_software_force_event === 1'b1) software_force_event_cnt++;
    if (cycles > 20000) begin
      fails++;
      $display("mismatch at %0t ns: run timed out", $time);
      complete_run();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [7:0]  ra [5];
    logic [31:0] rv [5];
    logic [22:0] x, ba, lo, hi, a;
    logic [15:0] dd, mm, bd;
    logic        n, m;
    seed = 32'h71E0;
    {rst_i, wb_cyc, wb_stb, wb_we, trace_done} = 5'b10000;
    {wb_adr, wb_dat, dly} = '0;
    bus = junk();
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    ra = '{OFS_MAIN, OFS_RANGE, OFS_FLAGS, OFS_NEXT, 8'hF0};
    rv = '{32'h0, 32'h0, 32'h0, {24'h0, NEXT_RST}, 32'h0};
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ra[i], 32'h0);
      chk(wb_q, rv[i]);
    end
    // Ch0, ch1 to state two, ch2 to state three
    wb(1'b1, OFS_NEXT, 32'hE5);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      x = r[22:0];
      r = rnd();
      dd = r[15:0];
      mm = (i % 4 == 0) ? 16'h0000 : r[31:16];
      r = rnd();
      bd = (i % 3 == 0) ? dd : ((i % 3 == 1) ? dd ^ ~mm : r[15:0]);
      n = i[1];
      ba = (i % 5 == 4) ? x ^ 23'h1 : x;
      m = em(n, dd, mm, bd) && (ba == x);
      cmp(0, {n, 7'h01}, x, dd, mm);
      fire(ba, 1'b0, 1'b0, 0, m ? 3'd2 : 3'd1, {3'b000, m}, bd);
    end
    cmp(0, 8'h00, x, 16'h0000, 16'h0000);
    cmp(1, 8'h81, x, 16'h0000, 16'h0000);
    fire(x, 1'b0, 1'b0, 0, 3'd2, 4'b0010);
    wb(1'b0, {4'h2, OFS_CMP_CTL}, 32'h0);
    chk(wb_q, 32'h01);
    cmp(1, 8'h00, x, 16'h0000, 16'h0000);
    cmp(0, 8'h01, x, 16'h0000, 16'h0000);
    cmp(2, 8'h01, x, 16'h0000, 16'h0000);
    fire(x, 1'b0, 1'b0, 0, 3'd2, 4'b0001);
    cmp(2, 8'h00, x, 16'h0000, 16'h0000);
    r = rnd();
    lo = {3'h0, r[19:1], 1'b0} + 23'h10;
    hi = lo + {14'h0, r[27:20], 1'b1};
    // B direction and size set against the bus: must be ignored
    cmp(0, 8'h01, lo, 16'h0000, 16'h0000);
    cmp(1, 8'h79, hi, 16'h0000, 16'h0000);
    for (int o = 0; o < 2; o++) begin
      wb(1'b1, OFS_RANGE, {29'h0, o[0], 2'b01});
      for (int j = 0; j < 6; j++) begin
        r = rnd();
        a = (j == 0) ? lo - 23'h1 : (j == 1) ? lo : (j == 2) ? hi : (j == 3) ? hi + 23'h1
          : (j == 4) ? lo + 23'h1 : r[22:0];
        m = o ? (a < lo || a > hi) : (a >= lo && a <= hi);
        fire(a, 1'b0, 1'b0, 0, m ? 3'd2 : 3'd1, {3'b000, m});
      end
    end
    // Extreme upper limit keeps high accesses quiet in outside mode
    wb(1'b1, OFS_RANGE, 32'h5);
    cmp(1, 8'h01, 23'h7FFFFF, 16'h0000, 16'h0000);
    fire(23'h7FFFF0, 1'b0, 1'b1, 0, 3'd1, 4'b0000);
    fire(lo - 23'h1, 1'b0, 1'b0, 0, 3'd2, 4'b0001);
    wb(1'b1, OFS_RANGE, 32'h1);
    cmp(1, 8'h00, hi, 16'h0000, 16'h0000);
    fire(lo + 23'h1, 1'b0, 1'b0, 0, 3'd1, 4'b0000);
    wb(1'b1, OFS_RANGE, 32'h0);
    r = rnd();
    dly <= {1'b0, r[2:0]} + 4'h1;
    cmp(0, 8'h03, x, 16'h0000, 16'h0000);
    fire(x, 1'b1, 1'b1, 12, 3'd1, 4'b0000);
    fire(x, 1'b1, 1'b0, 12, 3'd2, 4'b0001);
    cmp(0, 8'h00, x, 16'h0000, 16'h0000);
    for (int al = 0; al < 3; al++) begin
      // Force acts on the settings already stored, so arm with them first
      wb(1'b1, OFS_MAIN, 32'h31 | (32'(al) << 2));
      b0 = brk_cnt;
      t0 = software_force_event_cnt;
      wb(1'b1, OFS_MAIN, 32'h33 | (32'(al) << 2));
      repeat (3) @(posedge clk_i);
      #1;
      if (al == 2) begin
        chk(state, 3'd0);
        chk(brk_cnt - b0, 1);
      end else begin
        chk(state, 3'd4);
        chk(software_force_event_cnt - t0, 1);
        chk(brk_cnt - b0, 0);
        @(posedge clk_i);
        trace_done <= 1'b1;
        @(posedge clk_i);
        trace_done <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk(state, 3'd0);
        chk(brk_cnt - b0, 1);
      end
    end
    complete_run();
  end
endmodule : dct_trigger_tb_top
